// [rtl/scss_pkg.sv]
package scss_pkg;

    // Register byte offsets
    localparam logic [7:0] ADDR_OSC_CTRL  = 8'h00;
    localparam logic [7:0] ADDR_OSC_TUNE  = 8'h04;
    localparam logic [7:0] ADDR_T1_CTRL   = 8'h08;

    // Field positions
    localparam int IDLE_ENABLE_BIT   = 7;
    localparam int IRCF_LSB    = 4;
    localparam int STARTUP_DONE_FLAG_BIT    = 3;
    localparam int INTERNAL_STABLE_FLAG_BIT    = 2;
    localparam int SCS_LSB     = 0;
    localparam int LOW_FREQ_SOURCE_SEL_BIT  = 7;
    localparam int SECONDARY_RUNNING_FLAG_BIT   = 6;
    localparam int SECONDARY_OSC_ENABLE_BIT = 3;

    // Reset values and frequency code limits
    localparam logic [1:0] SCS_RESET    = 2'h0;
    localparam logic [2:0] IRCF_RESET   = 3'h4;
    localparam logic [2:0] IRCF_LOWEST  = 3'h0;
    localparam logic [2:0] IRCF_FASTEST = 3'h7;

    // Primary oscillator mode codes
    localparam logic [3:0] MODE_LP_XTAL   = 4'h0;
    localparam logic [3:0] MODE_XTAL      = 4'h1;
    localparam logic [3:0] MODE_HS_XTAL   = 4'h2;
    localparam logic [3:0] MODE_HS_PLL    = 4'h3;
    localparam logic [3:0] MODE_RC_CLKOUT = 4'h4;
    localparam logic [3:0] MODE_RC_IO     = 4'h5;
    localparam logic [3:0] MODE_INT_CLOCK_OUT_PIN  = 4'h6;
    localparam logic [3:0] MODE_INT_IO    = 4'h7;
    localparam logic [3:0] MODE_EC_CLKOUT = 4'h8;
    localparam logic [3:0] MODE_EC_IO     = 4'h9;

    // Clock switch pause, in ticks of old and new source
    localparam logic [1:0] OLD_PAUSE_TICKS = 2'h2;
    localparam logic [1:0] NEW_PAUSE_TICKS = 2'h3;

    // Start-up and settle counts, in source ticks
    localparam logic [9:0] OST_TICKS       = 10'h3ff;
    localparam logic [7:0] INT_STABLE_TICKS = 8'hff;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef enum logic [1:0] {SRC_PRI, SRC_SEC, SRC_INT} scss_src_t;

endpackage

// [rtl/scss_sync_edge.sv]
`timescale 1ns/1ps
module scss_sync_edge
(
    input  wire logic core_clk,
    input  wire logic rst_b,
    input  wire logic async_in,
    output logic      rise_r
);
    logic meta_r;
    logic sync_r;
    logic last_r;

    // Two-stage synchroniser, then rising edge pulse
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            last_r <= 1'b0;
            rise_r <= 1'b0;
        end
        else
        begin
            meta_r <= async_in;
            sync_r <= meta_r;
            last_r <= sync_r;
            rise_r <= sync_r & ~last_r;
        end
    end
endmodule

// [rtl/scss_postscale.sv]
`timescale 1ns/1ps
module scss_postscale
    import scss_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst_b,
    input  wire logic       fast_tick,
    input  wire logic       lprc_tick,
    input  wire logic [2:0] freq_sel,
    input  wire logic       low_src_sel,
    output logic            int_tick
);
    logic [7:0] div_cnt_r;

    // Divide mask per frequency code; 000 gives divide-by-256
    function automatic logic [7:0] div_mask(input logic [2:0] sel);
        logic [7:0] m;
        m = 8'hff;
        if (sel != IRCF_LOWEST)
            m = 8'(8'h80 >> sel) - 8'h01;
        return m;
    endfunction

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            div_cnt_r <= 8'h00;
        else if (fast_tick)
            div_cnt_r <= div_cnt_r + 8'h01;
    end

    always_comb
    begin
        if (freq_sel == IRCF_LOWEST && !low_src_sel)
            int_tick = lprc_tick; // RQ10
        else
            int_tick = fast_tick
                && ((div_cnt_r & div_mask(freq_sel)) == div_mask(freq_sel)); // RQ7 RQ8
    end
endmodule

// [rtl/scss_top.sv]
// Function
// (RQ1) Four-bit configuration picks one of ten modes
// (RQ2) Pin six gives clock/4 or I/O
// (RQ3) Oscillator pins are clock pins only when used
// (RQ4) Select field picks primary, secondary or internal
// (RQ5) Select write switches source after short pause
// (RQ6) Every reset clears the select field
// (RQ7) Frequency field picks internal block output rate
// (RQ8) Frequency writes act at once when internal
// (RQ9) Internal block defaults to 1 MHz
// (RQ10) Code 000: source bit picks lowest source
// (RQ11) Watchdog always clocked by low-power RC
// (RQ12) Start-up flag: timer done, primary running
// (RQ13) Stable flag: internal block stable and running
// (RQ14) Secondary flag at timer bit six
// (RQ15) At most one source flag set
// (RQ16) Idle enable chooses sleep or idle
// (RQ17) Secondary selection needs timer oscillator enable
// (RQ18) Software starts timer oscillator before sleeping
// (RQ19) Switch pauses two old, three new ticks
// (RQ20) Source flags read-only, track real source
`timescale 1ns/1ps
module scss_top
    import scss_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    input  wire logic [3:0]  cfg_osc_mode,
    input  wire logic        pri_osc_in,
    input  wire logic        sec_osc_in,
    input  wire logic        fast_osc_in,
    input  wire logic        lprc_osc_in,
    input  wire logic        sleep_exec,
    output logic             sys_clk_tick,
    output logic             wdt_clk_tick,
    output logic             sleep_enter,
    output logic             idle_enter,
    output logic             osc_in_is_clk,
    output logic             osc_out_is_osc,
    output logic             pin6_clkout_en,
    output logic             pin6_is_io,
    output logic             pin7_is_io,
    output logic             clock_out_pin
);
    typedef enum logic [1:0] {SW_RUN, SW_OLD, SW_NEW} scss_sw_t;

    logic        pri_rise;
    logic        sec_rise;
    logic        fast_rise;
    logic        lprc_rise;
    logic        int_tick;
    logic [3:0]  mode_meta_r;
    logic [3:0]  mode_r;
    logic        idle_en_r;
    logic [2:0]  ircf_r;
    logic [1:0]  scs_r;
    logic        low_freq_source_sel_r;
    logic        t1_oscen_r;
    logic        wr_pend_r;
    logic [7:0]  wr_addr_r;
    logic [31:0] rd_word;
    scss_sw_t    sw_state_r;
    scss_src_t   act_r;
    scss_src_t   new_src_r;
    scss_src_t   tgt_src;
    logic [1:0]  pause_cnt_r;
    logic [9:0]  ost_cnt_r;
    logic        ost_done_r;
    logic [7:0]  stab_cnt_r;
    logic        int_stable_r;
    logic        startup_done_flag_r;
    logic        internal_stable_flag_r;
    logic        secondary_running_flag_r;
    logic        int_mode;
    logic        int_driving;
    logic [1:0]  div4_cnt_r;

    scss_sync_edge u_pri_sync
    (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .async_in (pri_osc_in),
        .rise_r   (pri_rise)
    );

    scss_sync_edge u_sec_sync
    (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .async_in (sec_osc_in),
        .rise_r   (sec_rise)
    );

    scss_sync_edge u_fast_sync
    (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .async_in (fast_osc_in),
        .rise_r   (fast_rise)
    );

    scss_sync_edge u_lprc_sync
    (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .async_in (lprc_osc_in),
        .rise_r   (lprc_rise)
    );

    scss_postscale u_postscale
    (
        .core_clk    (core_clk),
        .rst_b       (rst_b),
        .fast_tick   (fast_rise),
        .lprc_tick   (lprc_rise),
        .freq_sel    (ircf_r),
        .low_src_sel (low_freq_source_sel_r),
        .int_tick    (int_tick)
    );

    // Tick of a given source; primary is the internal block in internal modes
    function automatic logic src_tick(input scss_src_t s, input logic imode,
                                      input logic p, input logic c, input logic i);
        logic t;
        t = 1'b0;
        case (s)
            SRC_PRI: t = imode ? i : p;
            SRC_SEC: t = c;
            SRC_INT: t = i;
            default: t = 1'b0;
        endcase
        return t;
    endfunction

    // Configuration mode, synchronised
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mode_meta_r <= MODE_LP_XTAL;
            mode_r      <= MODE_LP_XTAL;
        end
        else
        begin
            mode_meta_r <= cfg_osc_mode;
            mode_r      <= mode_meta_r; // RQ1
        end
    end

    assign int_mode = (mode_r == MODE_INT_CLOCK_OUT_PIN) || (mode_r == MODE_INT_IO);

    // Pin function decode
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            osc_in_is_clk  <= 1'b0;
            osc_out_is_osc <= 1'b0;
            pin6_clkout_en <= 1'b0;
            pin6_is_io     <= 1'b0;
            pin7_is_io     <= 1'b0;
        end
        else
        begin
            osc_in_is_clk  <= !int_mode; // RQ3
            osc_out_is_osc <= (mode_r <= MODE_HS_PLL); // RQ3
            pin6_clkout_en <= mode_r == MODE_RC_CLKOUT || mode_r == MODE_INT_CLOCK_OUT_PIN
                              || mode_r == MODE_EC_CLKOUT; // RQ2
            pin6_is_io     <= mode_r == MODE_RC_IO || mode_r == MODE_INT_IO
                              || mode_r == MODE_EC_IO; // RQ2
            pin7_is_io     <= int_mode; // RQ2 RQ3
        end
    end

    // AHB-Lite address phase and read data
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wr_pend_r <= 1'b0;
            if (hsel && hready && htrans == HTRANS_NONSEQ)
            begin
                wr_pend_r <= hwrite;
                wr_addr_r <= haddr[7:0];
                if (!hwrite)
                    hrdata <= rd_word;
            end
        end
    end

    always_comb
    begin
        rd_word = 32'h0000_0000;
        case (haddr[7:0])
            ADDR_OSC_CTRL:
            begin
                rd_word[IDLE_ENABLE_BIT]         = idle_en_r;
                rd_word[IRCF_LSB +: 3]     = ircf_r;
                rd_word[STARTUP_DONE_FLAG_BIT]          = startup_done_flag_r; // RQ20
                rd_word[INTERNAL_STABLE_FLAG_BIT]          = internal_stable_flag_r; // RQ20
                rd_word[SCS_LSB +: 2]      = scs_r;
            end
            ADDR_OSC_TUNE: rd_word[LOW_FREQ_SOURCE_SEL_BIT] = low_freq_source_sel_r;
            ADDR_T1_CTRL:
            begin
                rd_word[SECONDARY_RUNNING_FLAG_BIT]   = secondary_running_flag_r; // RQ14 RQ20
                rd_word[SECONDARY_OSC_ENABLE_BIT] = t1_oscen_r;
            end
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // Control register writes in the data phase; status bits not writable
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            idle_en_r  <= 1'b0;
            ircf_r     <= IRCF_RESET; // RQ9
            scs_r      <= SCS_RESET; // RQ6
            low_freq_source_sel_r   <= 1'b0;
            t1_oscen_r <= 1'b0;
        end
        else if (wr_pend_r)
        begin
            case (wr_addr_r)
                ADDR_OSC_CTRL:
                begin
                    idle_en_r <= hwdata[IDLE_ENABLE_BIT];
                    ircf_r    <= hwdata[IRCF_LSB +: 3]; // RQ8
                    scs_r     <= hwdata[SCS_LSB +: 2]; // RQ4
                end
                ADDR_OSC_TUNE: low_freq_source_sel_r <= hwdata[LOW_FREQ_SOURCE_SEL_BIT]; // RQ10
                ADDR_T1_CTRL: t1_oscen_r <= hwdata[SECONDARY_OSC_ENABLE_BIT];
                default: ;
            endcase
        end
    end

    // Requested source; secondary refused while its oscillator is off
    always_comb
    begin
        tgt_src = act_r;
        case (scs_r)
            2'h0: tgt_src = SRC_PRI; // RQ4
            2'h1: tgt_src = t1_oscen_r ? SRC_SEC : act_r; // RQ17
            default: tgt_src = SRC_INT; // RQ4
        endcase
    end

    // Glitch-free switch: two old ticks, then three new ticks
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sw_state_r  <= SW_RUN;
            act_r       <= SRC_PRI;
            new_src_r   <= SRC_PRI;
            pause_cnt_r <= 2'h0;
        end
        else
        begin
            case (sw_state_r)
                SW_RUN:
                    if (tgt_src != act_r)
                    begin
                        sw_state_r  <= SW_OLD; // RQ5
                        new_src_r   <= tgt_src;
                        pause_cnt_r <= 2'h0;
                    end
                SW_OLD:
                    if (src_tick(act_r, int_mode, pri_rise, sec_rise, int_tick))
                    begin
                        if (pause_cnt_r == OLD_PAUSE_TICKS - 2'h1)
                        begin
                            sw_state_r  <= SW_NEW; // RQ19
                            pause_cnt_r <= 2'h0;
                        end
                        else
                            pause_cnt_r <= pause_cnt_r + 2'h1;
                    end
                SW_NEW:
                    if (src_tick(new_src_r, int_mode, pri_rise, sec_rise, int_tick))
                    begin
                        if (pause_cnt_r == NEW_PAUSE_TICKS - 2'h1)
                        begin
                            sw_state_r <= SW_RUN; // RQ19
                            act_r      <= new_src_r; // RQ5
                        end
                        else
                            pause_cnt_r <= pause_cnt_r + 2'h1;
                    end
                default: sw_state_r <= SW_RUN;
            endcase
        end
    end

    // System and watchdog clock ticks, clock/4 output
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sys_clk_tick  <= 1'b0;
            wdt_clk_tick  <= 1'b0;
            div4_cnt_r    <= 2'h0;
            clock_out_pin <= 1'b0;
        end
        else
        begin
            sys_clk_tick <= (sw_state_r == SW_RUN)
                            && src_tick(act_r, int_mode, pri_rise, sec_rise, int_tick); // RQ5
            wdt_clk_tick <= lprc_rise; // RQ11
            if (sys_clk_tick)
                div4_cnt_r <= div4_cnt_r + 2'h1;
            clock_out_pin <= pin6_clkout_en && div4_cnt_r[1]; // RQ2
        end
    end

    // Start-up timer and internal block settle counters
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ost_cnt_r    <= 10'h000;
            ost_done_r   <= 1'b0;
            stab_cnt_r   <= 8'h00;
            int_stable_r <= 1'b0;
        end
        else
        begin
            if (int_mode)
            begin
                ost_cnt_r  <= 10'h000;
                ost_done_r <= 1'b0;
            end
            else if (pri_rise && !ost_done_r)
            begin
                ost_cnt_r  <= ost_cnt_r + 10'h001;
                ost_done_r <= ost_cnt_r == OST_TICKS - 10'h001;
            end
            if (fast_rise && !int_stable_r)
            begin
                stab_cnt_r   <= stab_cnt_r + 8'h01;
                int_stable_r <= stab_cnt_r == INT_STABLE_TICKS - 8'h01;
            end
        end
    end

    assign int_driving = (sw_state_r == SW_RUN)
                         && (act_r == SRC_INT || (act_r == SRC_PRI && int_mode));

    // Source status flags
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            startup_done_flag_r  <= 1'b0;
            internal_stable_flag_r  <= 1'b0;
            secondary_running_flag_r <= 1'b0;
        end
        else
        begin
            startup_done_flag_r  <= sw_state_r == SW_RUN && act_r == SRC_PRI
                       && !int_mode && ost_done_r; // RQ12 RQ15
            internal_stable_flag_r  <= int_driving && int_stable_r
                       && !(ircf_r == IRCF_LOWEST && !low_freq_source_sel_r); // RQ13 RQ15
            secondary_running_flag_r <= sw_state_r == SW_RUN && act_r == SRC_SEC; // RQ14 RQ15
        end
    end

    // Sleep instruction: full sleep or idle
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sleep_enter <= 1'b0;
            idle_enter  <= 1'b0;
        end
        else
        begin
            sleep_enter <= sleep_exec && !idle_en_r; // RQ16
            idle_enter  <= sleep_exec && idle_en_r; // RQ16
        end
    end

    a_status_onehot: assert property (@(posedge core_clk) disable iff (!rst_b) // RQ15
        $onehot0({startup_done_flag_r, internal_stable_flag_r, secondary_running_flag_r}))
        else $error("More than one source flag set");

    a_pause_no_tick: assert property (@(posedge core_clk) disable iff (!rst_b) // RQ5
        (sw_state_r != SW_RUN) |=> !sys_clk_tick)
        else $error("System tick during switch pause");

    a_pause_min_len: assert property (@(posedge core_clk) disable iff (!rst_b) // RQ19
        $rose(sw_state_r != SW_RUN) |-> (sw_state_r != SW_RUN) [*5])
        else $error("Switch pause shorter than five ticks");

    a_sec_flag_src: assert property (@(posedge core_clk) disable iff (!rst_b) // RQ14
        secondary_running_flag_r |-> $past(act_r) == SRC_SEC)
        else $error("Secondary flag without secondary source");

    a_sec_needs_en: assert property (@(posedge core_clk) disable iff (!rst_b) // RQ17
        (sw_state_r == SW_RUN && $past(sw_state_r) == SW_NEW && act_r == SRC_SEC)
        |-> $past(t1_oscen_r, 2) || scs_r != 2'h1)
        else $error("Secondary selected with oscillator off");

    a_wdt_lprc: assert property (@(posedge core_clk) disable iff (!rst_b) // RQ11
        wdt_clk_tick == $past(lprc_rise))
        else $error("Watchdog tick not from low-power RC");

    a_sleep_idle: assert property (@(posedge core_clk) disable iff (!rst_b) // RQ16
        sleep_exec |=> (idle_enter == $past(idle_en_r)) && (sleep_enter != idle_enter))
        else $error("Sleep or idle entry wrong");

    a_startup_done_flag_primary: assert property (@(posedge core_clk) disable iff (!rst_b) // RQ12
        startup_done_flag_r |-> $past(ost_done_r) && $past(act_r) == SRC_PRI)
        else $error("Start-up flag without primary clock");

    a_int_io_pins: assert property (@(posedge core_clk) disable iff (!rst_b) // RQ2
        (mode_r == MODE_INT_IO) |=> pin6_is_io && pin7_is_io && !pin6_clkout_en)
        else $error("Internal I/O mode pins wrong");

    c_switch_sec: cover property (@(posedge core_clk) disable iff (!rst_b)
        $rose(secondary_running_flag_r));
    c_switch_int: cover property (@(posedge core_clk) disable iff (!rst_b)
        $rose(internal_stable_flag_r));
    c_idle_entry: cover property (@(posedge core_clk) disable iff (!rst_b)
        idle_enter);
endmodule

// [bench/scss_osc_model.sv]
`timescale 1ns/1ps
module scss_osc_model
#(
    parameter int HALF_NS  = 30,
    parameter int PHASE_NS = 3
)
(
    output logic osc
);
    // Free-running source; phase offset keeps edges off the core clock edge
    // Runs from power-up, so it is stable before any sleep request
    initial
    begin
        osc = 1'b0;
        #(PHASE_NS);
        forever #(HALF_NS) osc = ~osc;
    end
endmodule

// [bench/tb_system_clock_source_selector.sv]
`timescale 1ns/1ps
module tb_system_clock_source_selector
    import scss_pkg::*;
;
    logic        core_clk     = 1'b0;
    logic        rst_b        = 1'b0;
    logic        hsel         = 1'b0;
    logic [31:0] haddr        = 32'h0;
    logic [1:0]  htrans       = 2'h0;
    logic        hwrite       = 1'b0;
    logic [2:0]  hsize        = 3'h2;
    logic [31:0] hwdata       = 32'h0;
    logic [3:0]  cfg_osc_mode = MODE_XTAL;
    logic        sleep_exec   = 1'b0;
    logic [31:0] hrdata;
    logic        hreadyout, hresp, pri_osc_in, sec_osc_in, fast_osc_in, lprc_osc_in;
    logic        sys_clk_tick, wdt_clk_tick, sleep_enter, idle_enter, clock_out_pin;
    logic        osc_in_is_clk, osc_out_is_osc, pin6_clkout_en, pin6_is_io, pin7_is_io;
    logic        clock_out_pin_q       = 1'b0;
    int          n_sys        = 0;
    int          n_wdt        = 0;
    int          n_clock_out_pin       = 0;
    int          cycles       = 0;
    int          n_mismatch   = 0;
    int          check_count  = 0;

    always #5 core_clk = ~core_clk;

    scss_osc_model u_pri (.osc(pri_osc_in));
    scss_osc_model #(.HALF_NS(50), .PHASE_NS(7)) u_sec (.osc(sec_osc_in));
    scss_osc_model #(.HALF_NS(20)) u_fast (.osc(fast_osc_in));
    scss_osc_model #(.HALF_NS(70), .PHASE_NS(9)) u_lprc (.osc(lprc_osc_in));

    scss_top DUT
    (
        .core_clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hrdata, .hresp, .cfg_osc_mode,
        .pri_osc_in, .sec_osc_in, .fast_osc_in, .lprc_osc_in, .sleep_exec,
        .sys_clk_tick, .wdt_clk_tick, .sleep_enter, .idle_enter, .osc_in_is_clk,
        .osc_out_is_osc, .pin6_clkout_en, .pin6_is_io, .pin7_is_io, .clock_out_pin
    );

    // Tick counters, sampled away from the active edge
    always @(negedge core_clk)
    begin
        n_sys  = n_sys + (sys_clk_tick === 1'b1);
        n_wdt  = n_wdt + (wdt_clk_tick === 1'b1);
        n_clock_out_pin = n_clock_out_pin + (clock_out_pin === 1'b1 && clock_out_pin_q === 1'b0);
        clock_out_pin_q = clock_out_pin;
    end

    task automatic end_of_test();
        $display("Checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            n_mismatch++;
            end_of_test();
        end
    end

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Rate counts may miss one tick at either end of the window
    function automatic logic [31:0] near(input int seen, input int exp);
        return ((seen - exp) <= 1 && (exp - seen) <= 1) ? exp : seen;
    endfunction

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge core_clk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wr ? d : 32'h0;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    initial
    begin
        logic [31:0] q;
        int          t0, d, r;
        void'($urandom(41));
        repeat (5) @(posedge core_clk);
        rst_b <= 1'b1;
        bus(0, ADDR_OSC_CTRL, 0, q);
        check("osc_ctrl reset", q, 32'h40);
        check("bus resp", {hreadyout, hresp}, 32'h2);
        bus(0, ADDR_T1_CTRL, 0, q);
        check("t1_ctrl reset", q, 32'h0);
        bus(1, 8'h0c, 32'hff, q);
        bus(0, 8'h0c, 0, q);
        check("unmapped", q, 32'h0);
        for (int m = 0; m < 10; m++)
        begin
            @(posedge core_clk);
            cfg_osc_mode <= 4'(m);
            repeat (5) @(posedge core_clk);
            #1;
            check("osc_in_is_clk", osc_in_is_clk, m != 6 && m != 7);
            check("osc_out_is_osc", osc_out_is_osc, m < 4);
            check("pin6_clkout", pin6_clkout_en, m == 4 || m == 6 || m == 8);
            check("pin6_is_io", pin6_is_io, m == 5 || m == 7 || m == 9);
            check("pin7_is_io", pin7_is_io, m == 6 || m == 7);
        end
        @(posedge core_clk);
        cfg_osc_mode <= MODE_RC_CLKOUT;
        repeat (20) @(posedge core_clk);
        t0 = n_clock_out_pin;
        repeat (480) @(posedge core_clk);
        check("clkout rate", near(n_clock_out_pin - t0, 20), 20);
        @(posedge core_clk);
        cfg_osc_mode <= MODE_XTAL;
        repeat (6400) @(posedge core_clk);
        bus(0, ADDR_OSC_CTRL, 0, q);
        check("startup flag", q, 32'h48);
        bus(1, ADDR_OSC_CTRL, 32'h41, q);
        repeat (100) @(posedge core_clk);
        bus(0, ADDR_T1_CTRL, 0, q);
        check("sec refused", q, 32'h0);
        bus(0, ADDR_OSC_CTRL, 0, q);
        check("pri kept", q & 32'hc, 32'h8);
        r = $urandom;
        bus(1, ADDR_T1_CTRL, 32'(r) | 32'h48, q);
        bus(0, ADDR_T1_CTRL, 0, q);
        check("t1 ro bit", q & 32'h48, 32'h8);
        bus(1, ADDR_OSC_CTRL, 32'h41, q);
        repeat (100) @(posedge core_clk);
        bus(0, ADDR_T1_CTRL, 0, q);
        check("sec running", q & 32'h48, 32'h48);
        bus(0, ADDR_OSC_CTRL, 0, q);
        check("one flag", q & 32'hc, 32'h0);
        bus(1, ADDR_OSC_CTRL, 32'h72, q);
        repeat (3) @(posedge core_clk);
        for (d = 3; d < 200; d++)
        begin
            @(posedge core_clk);
            #1;
            if (sys_clk_tick === 1'b1)
                break;
        end
        check("switch pause", d >= 18 && d <= 48, 1);
        for (int c = 7; c > 0; c--)
        begin
            bus(1, ADDR_OSC_CTRL, 32'(c << 4) | 32'h2, q);
            repeat (20) @(posedge core_clk);
            t0 = n_sys;
            repeat (512) @(posedge core_clk);
            check("int rate", near(n_sys - t0, 128 >> (7 - c)), 128 >> (7 - c));
            bus(0, ADDR_OSC_CTRL, 0, q);
            check("int stable", q, 32'(c << 4) | 32'h6);
        end
        for (int s = 0; s < 2; s++)
        begin
            r = $urandom;
            bus(1, ADDR_OSC_TUNE, {24'h0, s[0], r[6:0]}, q);
            bus(0, ADDR_OSC_TUNE, 0, q);
            check("tune", q & 32'h80, 32'(s << 7));
            bus(1, ADDR_OSC_CTRL, 32'h2, q);
            repeat (20) @(posedge core_clk);
            t0 = n_sys;
            d = n_wdt;
            repeat (2048) @(posedge core_clk);
            check("low rate", near(n_sys - t0, s ? 2 : 146), s ? 2 : 146);
            check("wdt rate", near(n_wdt - d, 146), 146);
            bus(0, ADDR_OSC_CTRL, 0, q);
            check("low flags", q & 32'hc, s ? 32'h4 : 32'h0);
        end
        for (int i = 0; i < 2; i++)
        begin
            bus(1, ADDR_OSC_CTRL, 32'(i << 7) | 32'h2, q);
            @(posedge core_clk);
            sleep_exec <= 1'b1;
            @(posedge core_clk);
            sleep_exec <= 1'b0;
            #1;
            check("sleep kind", {idle_enter, sleep_enter}, i ? 32'h2 : 32'h1);
            @(posedge core_clk);
            #1;
            check("sleep pulse", {idle_enter, sleep_enter}, 32'h0);
        end
        @(posedge core_clk);
        rst_b <= 1'b0;
        repeat (3) @(posedge core_clk);
        rst_b <= 1'b1;
        bus(0, ADDR_OSC_CTRL, 0, q);
        check("osc_ctrl rereset", q, 32'h40);
        bus(0, ADDR_OSC_TUNE, 0, q);
        check("tune rereset", q & 32'h80, 32'h0);
        end_of_test();
    end
endmodule
